/* File: src/anx_np_regs.sv */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

// How it works
// [RULE_01] expansion bits 15:7 ignore writes and read zero
// [RULE_02] location-able bit reads one
// [RULE_03] storage-location bit reads one; partner next pages land in register 8
// [RULE_04] parallel detect fault follows the detector, resets to zero
// [RULE_05] partner next-page ability read-only, resets zero
// [RULE_06] local next-page-able reads one, read-only
// [RULE_07] page received set on code word, cleared by expansion read
// [RULE_08] partner autoneg ability read-only, resets zero
// [RULE_09] software writes next-page request bit, resets zero
// [RULE_10] transmit ack bit is read-only, driven by the device
// [RULE_11] software writes message-page bit, resets one
// [RULE_12] software writes ack2 bit, resets zero
// [RULE_13] transmit toggle is inverse of previous exchanged toggle
// [RULE_14] transmit code resets to null page, writable
// [RULE_15] code is message code if message bit set, else unformatted
// [RULE_16] receive register stores partner next-page request
// [RULE_17] receive ack bit shows partner acknowledged our word
// [RULE_18] receive message-page bit captured, resets one
// [RULE_19] receive ack2 captured, resets zero
// [RULE_20] receive toggle holds inverse of previous exchanged toggle
// [RULE_21] partner base register holds partner base abilities
// [RULE_22] each new next page refreshes receive register and flag
module anx_np_regs
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// negotiation engine side
	input wire logic pd_fault_i,
	input wire logic partner_local_next_page_able_i,
	input wire logic partner_an_able_i,
	input wire logic base_page_valid_i,
	input wire logic [15:0] base_page_i,
	input wire logic next_page_valid_i,
	input wire logic [15:0] next_page_i,
	input wire logic local_ack_i,
	input wire logic tx_page_sent_i,
	output logic [15:0] tx_page_o,
	output logic tx_is_message_o
);

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic wr_tx;
	logic rd_exp;
	logic page_rx;
	assign wr_tx = reg_wr_i && (reg_addr_i == anx_regs_pkg::NP_TX_OFFSET);
	assign rd_exp = reg_rd_i && (reg_addr_i == anx_regs_pkg::EXPANSION_OFFSET);

	// ---------------------------------------------------------------
	// expansion status
	// ---------------------------------------------------------------
	logic pd_fault_ff;
	logic lp_np_ff;
	logic lp_an_ff;

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pd_fault_ff <= 1'b0;
			lp_np_ff <= 1'b0;
			lp_an_ff <= 1'b0;
		end
		else
		begin
			pd_fault_ff <= pd_fault_i; // [RULE_04]
			lp_np_ff <= partner_local_next_page_able_i; // [RULE_05]
			lp_an_ff <= partner_an_able_i; // [RULE_08]
		end
	end

	// a page received on either word raises the flag; set beats the read clear
	anx_flag u_page_rx
	(
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.set_i(base_page_valid_i || next_page_valid_i), // [RULE_07] [RULE_22]
		.clr_i(rd_exp), // [RULE_07]
		.flag_o(page_rx)
	);

	logic [15:0] exp_word;
	always_comb
	begin
		exp_word = 16'h0000; // [RULE_01]
		exp_word[anx_regs_pkg::EXP_LOC_ABLE_BIT] = anx_regs_pkg::EXP_LOC_ABLE_VAL; // [RULE_02]
		exp_word[anx_regs_pkg::EXP_STOR_LOC_BIT] = anx_regs_pkg::EXP_STOR_LOC_VAL; // [RULE_03]
		exp_word[anx_regs_pkg::EXP_PD_FAULT_BIT] = pd_fault_ff;
		exp_word[anx_regs_pkg::EXP_LP_NP_BIT] = lp_np_ff;
		exp_word[anx_regs_pkg::EXP_LOCAL_NP_BIT] = anx_regs_pkg::EXP_LOCAL_NP_VAL; // [RULE_06]
		exp_word[anx_regs_pkg::EXP_PAGE_RX_BIT] = page_rx;
		exp_word[anx_regs_pkg::EXP_LP_AN_BIT] = lp_an_ff;
	end

	// ---------------------------------------------------------------
	// toggle tracking: flips after each exchanged word
	// ---------------------------------------------------------------
	logic tx_toggle_ff;
	logic rx_toggle_ff;

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_toggle_ff <= 1'b0;
		else if (tx_page_sent_i)
			tx_toggle_ff <= ~tx_page_o[anx_regs_pkg::NP_TOGGLE_BIT]; // [RULE_13]
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rx_toggle_ff <= 1'b0;
		else if (next_page_valid_i)
			rx_toggle_ff <= ~next_page_i[anx_regs_pkg::NP_TOGGLE_BIT]; // [RULE_20]
	end

	// ---------------------------------------------------------------
	// transmit next page
	// ---------------------------------------------------------------
	logic tx_next_ff;
	logic tx_msg_ff;
	logic tx_ack2_ff;
	logic tx_ack_ff;
	logic [10:0] tx_code_ff;

	// writes to ack and toggle positions are dropped: those bits are device owned
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			tx_next_ff <= anx_regs_pkg::NP_NEXT_RST;
			tx_msg_ff <= anx_regs_pkg::NP_MSG_RST;
			tx_ack2_ff <= anx_regs_pkg::NP_ACK2_RST;
			tx_code_ff <= anx_regs_pkg::NP_CODE_RST;
		end
		else if (wr_tx)
		begin
			tx_next_ff <= reg_wdata_i[anx_regs_pkg::NP_NEXT_BIT]; // [RULE_09]
			tx_msg_ff <= reg_wdata_i[anx_regs_pkg::NP_MSG_BIT]; // [RULE_11]
			tx_ack2_ff <= reg_wdata_i[anx_regs_pkg::NP_ACK2_BIT]; // [RULE_12]
			tx_code_ff <= reg_wdata_i[anx_regs_pkg::NP_CODE_MSB:0]; // [RULE_14]
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_ack_ff <= 1'b0;
		else
			tx_ack_ff <= local_ack_i; // [RULE_10]
	end

	logic [15:0] tx_word;
	assign tx_word = {tx_next_ff, tx_ack_ff, tx_msg_ff, tx_ack2_ff, tx_toggle_ff, tx_code_ff};

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			tx_page_o <= {anx_regs_pkg::NP_NEXT_RST, 1'b0, anx_regs_pkg::NP_MSG_RST,
				anx_regs_pkg::NP_ACK2_RST, 1'b0, anx_regs_pkg::NP_CODE_RST};
			tx_is_message_o <= anx_regs_pkg::NP_MSG_RST;
		end
		else
		begin
			tx_page_o <= tx_word;
			// tells the engine how to read the code field
			tx_is_message_o <= tx_msg_ff; // [RULE_15]
		end
	end

	// ---------------------------------------------------------------
	// receive next page and partner base page
	// ---------------------------------------------------------------
	logic rx_next_ff;
	logic rx_ack_ff;
	logic rx_msg_ff;
	logic rx_ack2_ff;
	logic [10:0] rx_code_ff;
	logic [15:0] base_ff;

	// next pages go to register 8 only; base register keeps the base page
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rx_next_ff <= anx_regs_pkg::NP_NEXT_RST;
			rx_ack_ff <= 1'b0;
			rx_msg_ff <= anx_regs_pkg::NP_MSG_RST;
			rx_ack2_ff <= anx_regs_pkg::NP_ACK2_RST;
			rx_code_ff <= anx_regs_pkg::NP_CODE_RST;
		end
		else if (next_page_valid_i) // [RULE_03] [RULE_22]
		begin
			rx_next_ff <= next_page_i[anx_regs_pkg::NP_NEXT_BIT]; // [RULE_16]
			rx_ack_ff <= next_page_i[anx_regs_pkg::NP_ACK_BIT]; // [RULE_17]
			rx_msg_ff <= next_page_i[anx_regs_pkg::NP_MSG_BIT]; // [RULE_18]
			rx_ack2_ff <= next_page_i[anx_regs_pkg::NP_ACK2_BIT]; // [RULE_19]
			rx_code_ff <= next_page_i[anx_regs_pkg::NP_CODE_MSB:0];
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			base_ff <= anx_regs_pkg::PARTNER_BASE_RST;
		else if (base_page_valid_i)
			base_ff <= base_page_i; // [RULE_21]
	end

	// ---------------------------------------------------------------
	// read mux: unmapped addresses read zero, a cycle after the strobe
	// ---------------------------------------------------------------
	logic [15:0] nxt_rdata;
	always_comb
	begin
		case (reg_addr_i)
			anx_regs_pkg::PARTNER_BASE_OFFSET: nxt_rdata = base_ff;
			anx_regs_pkg::EXPANSION_OFFSET: nxt_rdata = exp_word;
			anx_regs_pkg::NP_TX_OFFSET: nxt_rdata = tx_word;
			anx_regs_pkg::NP_RX_OFFSET: nxt_rdata = {rx_next_ff, rx_ack_ff, rx_msg_ff,
				rx_ack2_ff, rx_toggle_ff, rx_code_ff};
			default: nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i)
			reg_rdata_o <= nxt_rdata;
		else
			reg_rdata_o <= 16'h0000;
	end

endmodule

/* File: pkg/anx_regs_pkg.sv */
package anx_regs_pkg;

	// ---------------------------------------------------------------
	// register offsets (management register index)
	// ---------------------------------------------------------------
	localparam logic [4:0] PARTNER_BASE_OFFSET = 5'h05;
	localparam logic [4:0] EXPANSION_OFFSET = 5'h06;
	localparam logic [4:0] NP_TX_OFFSET = 5'h07;
	localparam logic [4:0] NP_RX_OFFSET = 5'h08;

	// ---------------------------------------------------------------
	// expansion status fields
	// ---------------------------------------------------------------
	localparam int EXP_LOC_ABLE_BIT = 6;
	localparam int EXP_STOR_LOC_BIT = 5;
	localparam int EXP_PD_FAULT_BIT = 4;
	localparam int EXP_LP_NP_BIT = 3;
	localparam int EXP_LOCAL_NP_BIT = 2;
	localparam int EXP_PAGE_RX_BIT = 1;
	localparam int EXP_LP_AN_BIT = 0;
	localparam logic EXP_LOC_ABLE_VAL = 1'h1;
	localparam logic EXP_STOR_LOC_VAL = 1'h1;
	localparam logic EXP_LOCAL_NP_VAL = 1'h1;

	// ---------------------------------------------------------------
	// next page word fields (transmit and receive alike)
	// ---------------------------------------------------------------
	localparam int NP_NEXT_BIT = 15;
	localparam int NP_ACK_BIT = 14;
	localparam int NP_MSG_BIT = 13;
	localparam int NP_ACK2_BIT = 12;
	localparam int NP_TOGGLE_BIT = 11;
	localparam int NP_CODE_MSB = 10;
	localparam logic NP_NEXT_RST = 1'h0;
	localparam logic NP_MSG_RST = 1'h1;
	localparam logic NP_ACK2_RST = 1'h0;
	localparam logic [10:0] NP_CODE_RST = 11'h001;
	localparam logic [15:0] PARTNER_BASE_RST = 16'h0000;

endpackage

/* File: src/anx_flag.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// sticky event flag: set beats clear in the same cycle
// ---------------------------------------------------------------
module anx_flag
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);

	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clr_i)
			flag_o <= 1'b0;
	end

endmodule

/* File: tb/anx_np_regs_chk.sv */
`timescale 1ns/1ps
module anx_np_regs_chk
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic base_page_valid_i,
	input wire logic next_page_valid_i,
	input wire logic [15:0] next_page_i,
	input wire logic local_ack_i,
	input wire logic tx_page_sent_i,
	input wire logic [15:0] tx_page_o,
	input wire logic tx_is_message_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic rd6;
	logic quiet6;
	assign rd6 = reg_rd_i && reg_addr_i == 5'h06;
	assign quiet6 = rd6 && !base_page_valid_i && !next_page_valid_i;
	a_exp_fixed: assert property (rd6 |=> (reg_rdata_o & 16'hFFE4) == 16'h0064)
		else $error("expansion fixed bits wrong");
	a_page_set: assert property (next_page_valid_i ##1 !rd6 ##1 rd6 |=> reg_rdata_o[1])
		else $error("page received flag not set");
	a_page_clear: assert property (quiet6 ##1 (!base_page_valid_i && !next_page_valid_i)
		##1 quiet6 |=> !reg_rdata_o[1])
		else $error("page received flag not cleared by read");
	a_rx_capture: assert property (next_page_valid_i ##1 !next_page_valid_i
		##1 (reg_rd_i && reg_addr_i == 5'h08 && !next_page_valid_i)
		|=> reg_rdata_o == ($past(next_page_i, 3) ^ 16'h0800))
		else $error("received page not captured");
	a_tx_write: assert property ((reg_wr_i && reg_addr_i == 5'h07) ##1 !reg_wr_i
		|=> (tx_page_o & 16'hB7FF) == ($past(reg_wdata_i, 2) & 16'hB7FF))
		else $error("transmit word does not follow write");
	a_tx_toggle: assert property (tx_page_sent_i ##1 !tx_page_sent_i
		|=> ((tx_page_o ^ $past(tx_page_o)) & 16'h0800) != 16'h0000)
		else $error("transmit toggle did not flip");
	a_tx_ack: assert property (tx_page_o[14] == $past(local_ack_i, 2))
		else $error("transmit ack does not follow engine");
	a_msg_flag: assert property (tx_is_message_o == tx_page_o[13])
		else $error("message flag differs from word");
endmodule

bind anx_np_regs anx_np_regs_chk u_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .base_page_valid_i, .next_page_valid_i, .next_page_i,
	.local_ack_i, .tx_page_sent_i, .tx_page_o, .tx_is_message_o);

/* File: tb/anx_engine_model.sv */
`timescale 1ns/1ps
module anx_engine_model
(
	input wire logic sys_clk_i,
	output logic pd_fault_o,
	output logic local_next_page_able_o,
	output logic an_able_o,
	output logic ack_o,
	output logic base_valid_o,
	output logic [15:0] base_page_o,
	output logic next_valid_o,
	output logic [15:0] next_page_o,
	output logic sent_o
);
	initial
	begin
		{pd_fault_o, local_next_page_able_o, an_able_o, ack_o, base_valid_o, next_valid_o, sent_o} = 7'h00;
		base_page_o = 16'h0000;
		next_page_o = 16'h0000;
	end
	task automatic levels(input logic [3:0] v);
		@(posedge sys_clk_i);
		{pd_fault_o, local_next_page_able_o, an_able_o, ack_o} <= v;
	endtask
	// word is inverted after the pulse so stale data cannot pass
	task automatic page(input logic nxt, input logic [15:0] w);
		@(posedge sys_clk_i);
		next_page_o <= w;
		base_page_o <= w;
		next_valid_o <= nxt;
		base_valid_o <= !nxt;
		@(posedge sys_clk_i);
		next_valid_o <= 1'b0;
		base_valid_o <= 1'b0;
		next_page_o <= ~w;
		base_page_o <= ~w;
	endtask
	task automatic sent();
		@(posedge sys_clk_i);
		sent_o <= 1'b1;
		@(posedge sys_clk_i);
		sent_o <= 1'b0;
	endtask
endmodule

/* File: tb/autoneg_next_page_registers_test.sv */
`timescale 1ns/1ps
module autoneg_next_page_registers_test;
	logic sys_clk_i;
	logic sys_rst_i;
	logic [4:0] reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [15:0] reg_rdata_o;
	logic pd, npa, ana, ack, bval, nval, sent, txm;
	logic [15:0] bw, nw, txp;
	int n_fail = 0;
	int checks_done = 0;
	initial
	begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	anx_np_regs u_anx_np_regs (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .pd_fault_i(pd), .partner_local_next_page_able_i(npa), .partner_an_able_i(ana),
		.base_page_valid_i(bval), .base_page_i(bw), .next_page_valid_i(nval), .next_page_i(nw),
		.local_ack_i(ack), .tx_page_sent_i(sent), .tx_page_o(txp), .tx_is_message_o(txm));
	anx_engine_model u_anx_engine_model (.sys_clk_i, .pd_fault_o(pd), .local_next_page_able_o(npa),
		.an_able_o(ana), .ack_o(ack), .base_valid_o(bval), .base_page_o(bw), .next_valid_o(nval),
		.next_page_o(nw), .sent_o(sent));
	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rdc(5'h06, 16'h0064);
		rdc(5'h07, 16'h2001);
		rdc(5'h08, 16'h2001);
		rdc(5'h05, 16'h0000);
		wr(5'h06, 16'hFFFF);
		wr(5'h08, 16'hFFFF);
		wr(5'h1F, 16'hFFFF);
		rdc(5'h06, 16'h0064);
		rdc(5'h08, 16'h2001);
		rdc(5'h1F, 16'h0000);
	endtask
	task automatic t_status();
		u_anx_engine_model.levels(4'hE);
		rdc(5'h06, 16'h007D);
		u_anx_engine_model.levels(4'h1);
		rdc(5'h06, 16'h0064);
		rdc(5'h07, 16'h6001);
		u_anx_engine_model.levels(4'h0);
	endtask
	task automatic t_tx(input logic [15:0] d, input logic [15:0] exp);
		wr(5'h07, d);
		@(posedge sys_clk_i);
		#1;
		chk(txp, exp);
		chk({15'h0000, txm}, {15'h0000, exp[13]});
		rdc(5'h07, exp);
	endtask
	task automatic t_toggle();
		u_anx_engine_model.sent();
		rdc(5'h07, 16'h2801);
		u_anx_engine_model.sent();
		rdc(5'h07, 16'h2001);
	endtask
	task automatic t_rx();
		u_anx_engine_model.page(1'b1, 16'hD5AA);
		u_anx_engine_model.page(1'b1, 16'h2801);
		rdc(5'h06, 16'h0066);
		rdc(5'h06, 16'h0064);
		rdc(5'h08, 16'h2001);
		u_anx_engine_model.page(1'b1, 16'hD5AA);
		rdc(5'h08, 16'hDDAA);
		rdc(5'h06, 16'h0066);
		u_anx_engine_model.page(1'b0, 16'hA5E1);
		rdc(5'h05, 16'hA5E1);
		rdc(5'h08, 16'hDDAA);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		sys_rst_i = 1'b1;
		reg_addr_i = 5'h00;
		reg_wdata_i = 16'h0000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_status();
		t_tx(16'hFFFF, 16'hB7FF);
		t_tx(16'h0000, 16'h0000);
		t_tx(16'h2001, 16'h2001);
		t_toggle();
		t_rx();
		conclude();
	end
	initial
	begin
		repeat (2000) @(posedge sys_clk_i);
		n_fail++;
		conclude();
	end
endmodule
